// file: reclose_pkg.sv
// Constants, types and register map of the breaker reclose sequencer.
// Assumes a 200 MHz mclk; all sequencer timers count a common tick.
package reclose_pkg;

  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned TICK_US         = 10;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W          = 12;

  // AXI4-Lite byte addresses
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_SHOTS       = 8'h04;
  localparam logic [7:0] ADDR_DEAD1       = 8'h08;
  localparam logic [7:0] ADDR_DEAD2       = 8'h0c;
  localparam logic [7:0] ADDR_DEAD3       = 8'h10;
  localparam logic [7:0] ADDR_DEAD4       = 8'h14;
  localparam logic [7:0] ADDR_RECLAIM     = 8'h18;
  localparam logic [7:0] ADDR_ENERGY      = 8'h1c;
  localparam logic [7:0] ADDR_STATUS      = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_DT_ON_PROT = 0;
  localparam int unsigned CTRL_REMOTE_AUTO= 1;

  // Shot register fields
  localparam int unsigned SHOT_MAIN_LSB   = 0;
  localparam int unsigned SHOT_SEF_LSB    = 4;

  localparam logic [1:0] RESP_OKAY        = 2'b00;
  localparam logic [1:0] RESP_SLVERR      = 2'b10;

  localparam logic [2:0] SHOTS_MAX        = 3'h4;
  localparam logic [2:0] SHOTS_MIN        = 3'h1;
  localparam logic [2:0] MAIN_SHOTS_RST   = 3'h1;
  localparam logic [2:0] SEF_SHOTS_RST    = 3'h1;
  localparam logic [23:0] DEAD_RST        = 24'h00_0064;
  localparam logic [23:0] RECLAIM_RST     = 24'h00_03e8;
  localparam logic [23:0] ENERGY_RST      = 24'h00_01f4;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TRIPPED = 3'b001,
    ST_DEAD    = 3'b011,
    ST_CHECK   = 3'b010,
    ST_CLOSING = 3'b110,
    ST_RECLAIM = 3'b111,
    ST_LOCKOUT = 3'b101
  } seq_state_e;

  // Protection and external initiation inputs
  typedef struct packed {
    logic main_start;
    logic main_trip;
    logic sef_start;
    logic sef_trip;
    logic external_trip_initiate;
    logic external_start_initiate;
  } prot_in_s;

  // Breaker and system condition inputs
  typedef struct packed {
    logic breaker_closed;
    logic breaker_energy_ok;
    logic breaker_in_service;
    logic one_side_live;
    logic both_live_sync;
    logic dead_time_permit;
    logic dead_time_run_enable;
  } cb_in_s;

  // Mode and interlock inputs
  typedef struct packed {
    logic auto_mode_select_a;
    logic auto_mode_select_b;
    logic live_work_mode;
    logic remote_control_mode;
    logic reclose_block;
    logic lockout_reset;
    logic forced_restart;
    logic trip_test_request;
    logic skip_first_shot;
    logic reclaim_inhibit;
    logic delayed_reclose_complete;
  } mode_in_s;

  // Status outputs
  typedef struct packed {
    logic reclose_in_progress;
    logic delayed_reclose_in_progress;
    logic three_phase_close;
    logic trip_test_out;
    logic lockout;
    logic energy_alarm;
    logic in_service;
    logic block_inst_prot;
    logic [2:0] seq_count;
  } status_out_s;

endpackage

// file: breaker_reclose_sequencer.sv
// Breaker auto-reclose sequencer with AXI4-Lite settings and status.
// Assumes all status inputs are asynchronous pins; one clock, no interrupt.
`timescale 1ns/10ps
`default_nettype none

module breaker_reclose_sequencer (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  // AXI4-Lite slave
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Pin inputs
  input  wire reclose_pkg::prot_in_s        prot_in,
  input  wire reclose_pkg::cb_in_s          cb_in,
  input  wire reclose_pkg::mode_in_s        mode_in,
  // Status outputs
  output reclose_pkg::status_out_s          status_out
);

  localparam int unsigned PW = $bits(reclose_pkg::prot_in_s) + $bits(reclose_pkg::cb_in_s)
                               + $bits(reclose_pkg::mode_in_s);

  // Three-stage input synchroniser; a change counts once stages 2 and 3 agree
  logic [PW-1:0] s1_r, s2_r, s3_r, pin_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      pin_r <= '0;
    end else begin
      s1_r <= {prot_in, cb_in, mode_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < PW; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          pin_r[i] <= s3_r[i];
        end
      end
    end
  end

  reclose_pkg::prot_in_s pr;
  reclose_pkg::cb_in_s   cb;
  reclose_pkg::mode_in_s md;
  assign {pr, cb, md} = pin_r;

  // Settings registers
  logic [31:0] ctrl_r;
  logic [2:0]  main_shots_r, sef_shots_r;
  logic [23:0] dead_r [4];
  logic [23:0] reclaim_r, energy_r;

  function automatic logic [2:0] clamp_shots(input logic [3:0] v);
    if (v[2:0] < reclose_pkg::SHOTS_MIN || v > 4'(reclose_pkg::SHOTS_MAX)) begin
      clamp_shots = reclose_pkg::SHOTS_MIN;
    end else begin
      clamp_shots = v[2:0];
    end
  endfunction

  // AXI write channel
  logic [7:0]  awaddr_r;
  logic        aw_have_r, w_have_r;
  logic [31:0] wdata_r;
  logic        wr_do;
  assign wr_do = aw_have_r && w_have_r && !s_axi_bvalid;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a <= reclose_pkg::ADDR_STATUS) && (a[1:0] == 2'b00);
  endfunction

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= reclose_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_do) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_addr(awaddr_r) ? reclose_pkg::RESP_OKAY : reclose_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Settings, written whole-word; wstrb is ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r       <= '0;
      main_shots_r <= reclose_pkg::MAIN_SHOTS_RST;
      sef_shots_r  <= reclose_pkg::SEF_SHOTS_RST;
      reclaim_r    <= reclose_pkg::RECLAIM_RST;
      energy_r     <= reclose_pkg::ENERGY_RST;
      for (int i = 0; i < 4; i++) begin
        dead_r[i] <= reclose_pkg::DEAD_RST;
      end
    end else if (wr_do) begin
      case (awaddr_r)
        reclose_pkg::ADDR_CTRL: ctrl_r <= wdata_r;
        reclose_pkg::ADDR_SHOTS: begin
          main_shots_r <= clamp_shots(wdata_r[reclose_pkg::SHOT_MAIN_LSB +: 4]);
          sef_shots_r  <= clamp_shots(wdata_r[reclose_pkg::SHOT_SEF_LSB +: 4]);
        end
        reclose_pkg::ADDR_DEAD1: dead_r[0] <= wdata_r[23:0];
        reclose_pkg::ADDR_DEAD2: dead_r[1] <= wdata_r[23:0];
        reclose_pkg::ADDR_DEAD3: dead_r[2] <= wdata_r[23:0];
        reclose_pkg::ADDR_DEAD4: dead_r[3] <= wdata_r[23:0];
        reclose_pkg::ADDR_RECLAIM: reclaim_r <= wdata_r[23:0];
        reclose_pkg::ADDR_ENERGY: energy_r <= wdata_r[23:0];
        default: ;
      endcase
    end
  end

  // Common timer tick
  logic [reclose_pkg::TICK_W-1:0] pre_r;
  logic                           tick_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (pre_r == reclose_pkg::TICK_W'(reclose_pkg::TICK_CYCLES - 1));
      pre_r  <= (pre_r == reclose_pkg::TICK_W'(reclose_pkg::TICK_CYCLES - 1)) ? '0 : pre_r + 1'b1;
    end
  end

  // Mode decode
  logic live_work, auto_mode, prot_op, sef_seq_r, skip_d_r, test_d_r;
  assign live_work = md.live_work_mode;
  assign auto_mode = !live_work && (md.remote_control_mode
                     ? ctrl_r[reclose_pkg::CTRL_REMOTE_AUTO]
                     : (md.auto_mode_select_a || md.auto_mode_select_b));
  assign prot_op   = pr.main_trip || pr.sef_trip || pr.main_start || pr.sef_start
                     || pr.external_trip_initiate || pr.external_start_initiate;

  // Sequencer
  reclose_pkg::seq_state_e st_r;
  logic [2:0]  cnt_r;
  logic [23:0] tmr_r;
  logic        primed_r, reclaim_hold_r, dar_done_r, lock_cause_r;
  logic [2:0]  shots;
  logic        dt_src_ok, sys_ok, prime_now;
  assign shots     = sef_seq_r ? sef_shots_r : main_shots_r;
  assign dt_src_ok = ctrl_r[reclose_pkg::CTRL_DT_ON_PROT] ? !prot_op : !cb.breaker_closed;
  assign sys_ok    = cb.one_side_live || cb.both_live_sync;
  assign prime_now = !cb.breaker_closed && !prot_op && cb.dead_time_permit;
  assign lock_cause_r = md.reclose_block || prot_op;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r           <= reclose_pkg::ST_IDLE;
      cnt_r          <= '0;
      tmr_r          <= '0;
      primed_r       <= 1'b0;
      reclaim_hold_r <= 1'b0;
      dar_done_r     <= 1'b0;
      sef_seq_r      <= 1'b0;
      skip_d_r       <= 1'b0;
      status_out     <= '0;
    end else begin
      skip_d_r <= md.skip_first_shot;
      status_out.trip_test_out <= md.trip_test_request && !test_d_r;
      if (md.skip_first_shot && !skip_d_r && cnt_r < reclose_pkg::SHOTS_MAX) begin
        cnt_r <= cnt_r + 1'b1;
      end
      if (md.reclose_block && st_r != reclose_pkg::ST_LOCKOUT) begin
        st_r <= reclose_pkg::ST_LOCKOUT;
        tmr_r <= '0;
        // A pending close must not outlive the sequence
        status_out.three_phase_close <= 1'b0;
      end else begin
        case (st_r)
          reclose_pkg::ST_IDLE: begin
            if (prot_op && auto_mode
                && (cb.breaker_in_service || md.forced_restart)) begin
              sef_seq_r  <= pr.sef_trip || pr.sef_start;
              st_r       <= reclose_pkg::ST_TRIPPED;
              primed_r   <= 1'b0;
              dar_done_r <= 1'b0;
              cnt_r      <= cnt_r + 1'b1;
            end
          end
          reclose_pkg::ST_TRIPPED: begin
            if (prime_now) begin
              primed_r <= 1'b1;
            end
            if ((primed_r || prime_now) && dt_src_ok) begin
              st_r  <= reclose_pkg::ST_DEAD;
              tmr_r <= '0;
            end
          end
          reclose_pkg::ST_DEAD: begin
            if (!cb.dead_time_run_enable) begin
              tmr_r <= '0;
            end else if (tmr_r >= dead_r[2'(cnt_r - 1'b1)]) begin
              st_r  <= reclose_pkg::ST_CHECK;
              tmr_r <= '0;
            end else if (tick_r) begin
              tmr_r <= tmr_r + 1'b1;
            end
          end
          reclose_pkg::ST_CHECK: begin
            if (cb.breaker_energy_ok && sys_ok) begin
              st_r <= reclose_pkg::ST_CLOSING;
              status_out.three_phase_close <= 1'b1;
            end else if (!cb.breaker_energy_ok && tmr_r >= energy_r) begin
              st_r <= reclose_pkg::ST_LOCKOUT;
              status_out.energy_alarm <= 1'b1;
            end else if (tick_r) begin
              tmr_r <= tmr_r + 1'b1;
            end
          end
          reclose_pkg::ST_CLOSING: begin
            if (cb.breaker_closed) begin
              status_out.three_phase_close <= 1'b0;
              st_r           <= reclose_pkg::ST_RECLAIM;
              tmr_r          <= '0;
              reclaim_hold_r <= md.reclaim_inhibit;
            end
          end
          reclose_pkg::ST_RECLAIM: begin
            if (prot_op) begin
              if (cnt_r >= shots) begin
                st_r <= reclose_pkg::ST_LOCKOUT;
              end else begin
                st_r     <= reclose_pkg::ST_TRIPPED;
                primed_r <= 1'b0;
                cnt_r    <= cnt_r + 1'b1;
              end
            end else if (tmr_r >= reclaim_r) begin
              st_r  <= reclose_pkg::ST_IDLE;
              cnt_r <= '0;
            end else if (tick_r && !reclaim_hold_r) begin
              tmr_r <= tmr_r + 1'b1;
            end
          end
          reclose_pkg::ST_LOCKOUT: begin
            if (md.lockout_reset && !lock_cause_r) begin
              st_r  <= reclose_pkg::ST_IDLE;
              cnt_r <= '0;
              status_out.energy_alarm <= 1'b0;
            end
          end
          default: st_r <= reclose_pkg::ST_IDLE;
        endcase
      end
      if (md.delayed_reclose_complete && st_r != reclose_pkg::ST_IDLE) begin
        dar_done_r <= 1'b1;
      end
      status_out.seq_count <= cnt_r;
      status_out.lockout   <= (st_r == reclose_pkg::ST_LOCKOUT);
      status_out.in_service <= auto_mode;
      status_out.block_inst_prot <= auto_mode && !live_work && cnt_r != '0;
      status_out.reclose_in_progress <= st_r != reclose_pkg::ST_IDLE
                                        && st_r != reclose_pkg::ST_LOCKOUT;
      status_out.delayed_reclose_in_progress <= st_r != reclose_pkg::ST_IDLE
                                        && st_r != reclose_pkg::ST_LOCKOUT && !dar_done_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      test_d_r <= 1'b0;
    end else begin
      test_d_r <= md.trip_test_request;
    end
  end

  // AXI read channel
  logic [31:0] rd_val;
  always_comb begin
    rd_val = '0;
    case (s_axi_araddr)
      reclose_pkg::ADDR_CTRL:    rd_val = ctrl_r;
      reclose_pkg::ADDR_SHOTS:   rd_val = {24'h00_0000, 1'b0, sef_shots_r, 1'b0, main_shots_r};
      reclose_pkg::ADDR_DEAD1:   rd_val = {8'h00, dead_r[0]};
      reclose_pkg::ADDR_DEAD2:   rd_val = {8'h00, dead_r[1]};
      reclose_pkg::ADDR_DEAD3:   rd_val = {8'h00, dead_r[2]};
      reclose_pkg::ADDR_DEAD4:   rd_val = {8'h00, dead_r[3]};
      reclose_pkg::ADDR_RECLAIM: rd_val = {8'h00, reclaim_r};
      reclose_pkg::ADDR_ENERGY:  rd_val = {8'h00, energy_r};
      reclose_pkg::ADDR_STATUS:  rd_val = {17'h0_0000, primed_r, 3'(st_r), 11'(status_out)};
      default:                   rd_val = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= reclose_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= known_addr(s_axi_araddr) ? reclose_pkg::RESP_OKAY : reclose_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Assertions
  property p_block_lock;
    @(posedge mclk) disable iff (!rst_n)
      md.reclose_block |=> st_r == reclose_pkg::ST_LOCKOUT;
  endproperty
  a_block_lock: assert property (p_block_lock) else $error("block did not lock out");

  property p_close_ok;
    @(posedge mclk) disable iff (!rst_n)
      $rose(status_out.three_phase_close) |-> $past(sys_ok) && $past(cb.breaker_energy_ok);
  endproperty
  a_close_ok: assert property (p_close_ok) else $error("close without checks");

  property p_live_work;
    @(posedge mclk) disable iff (!rst_n)
      live_work |=> !status_out.in_service && !status_out.block_inst_prot;
  endproperty
  a_live_work: assert property (p_live_work) else $error("live work not honoured");

  property p_dead_hold;
    @(posedge mclk) disable iff (!rst_n)
      st_r == reclose_pkg::ST_DEAD && !cb.dead_time_run_enable |=> tmr_r == '0;
  endproperty
  a_dead_hold: assert property (p_dead_hold) else $error("dead timer ran while disabled");

  property p_reset_gate;
    @(posedge mclk) disable iff (!rst_n)
      st_r == reclose_pkg::ST_LOCKOUT && lock_cause_r && !md.reclose_block
        |=> st_r == reclose_pkg::ST_LOCKOUT;
  endproperty
  a_reset_gate: assert property (p_reset_gate) else $error("lockout left with cause");

  property p_prog;
    @(posedge mclk) disable iff (!rst_n)
      status_out.delayed_reclose_in_progress |-> status_out.reclose_in_progress;
  endproperty
  a_prog: assert property (p_prog) else $error("delayed flag without progress");

  property p_energy;
    @(posedge mclk) disable iff (!rst_n)
      $rose(status_out.energy_alarm) |-> $past(tmr_r) >= $past(energy_r);
  endproperty
  a_energy: assert property (p_energy) else $error("energy lockout too early");

  property p_test;
    @(posedge mclk) disable iff (!rst_n)
      status_out.trip_test_out |=> !status_out.trip_test_out;
  endproperty
  a_test: assert property (p_test) else $error("trip test not a pulse");

endmodule
`default_nettype wire

// file: breaker_model.sv
// Circuit breaker model: opens on a trip, closes a fixed delay after a close.
// Assumes commands are levels sampled on mclk.
`timescale 1ns/10ps
`default_nettype none
module breaker_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Commands
  input  wire logic close_cmd,
  input  wire logic trip_cmd,
  // Main contacts
  output logic      closed
);
  logic [7:0] dly_r;
  always_ff @(posedge mclk) begin
    if (!rst_n || !close_cmd || closed) dly_r <= 8'h00;
    else dly_r <= dly_r + 8'h01;
  end
  // Mechanism takes 21 cycles to close
  always_ff @(posedge mclk) begin
    if (!rst_n) closed <= 1'b1;
    else if (trip_cmd) closed <= 1'b0;
    else if (dly_r == 8'h14) closed <= 1'b1;
  end
endmodule
`default_nettype wire

// file: breaker_reclose_sequencer_test.sv
// Bench for the reclose sequencer: settings, reclose cycles, lockout, modes.
// Assumes breaker_model as the breaker on the far side.
`timescale 1ns/10ps
`default_nettype none
module breaker_reclose_sequencer_test;
  logic                     mclk, rst_n, closed, mc;
  logic [7:0]               aw, ar;
  logic [31:0]              wd, rd, v, d;
  logic [3:0]               ws, m, s;
  logic                     awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
  logic [1:0]               bre, rre, r;
  reclose_pkg::prot_in_s    prot;
  reclose_pkg::cb_in_s      cb, cbw;
  reclose_pkg::mode_in_s    md;
  reclose_pkg::status_out_s st;
  int                       seed = 10608;
  int                       n_mismatch = 0;
  int                       n_checks = 0;

  breaker_reclose_sequencer uut (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bre), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rre), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .prot_in(prot), .cb_in(cbw), .mode_in(md), .status_out(st));
  breaker_model bkr (.mclk(mclk), .rst_n(rst_n), .close_cmd(st.three_phase_close | mc),
    .trip_cmd(prot.main_trip | st.trip_test_out), .closed(closed));

  always_comb begin
    cbw = cb;
    cbw.breaker_closed = closed;
  end
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    aw <= a;
    wd <= dat;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge mclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    r = bre;
    br <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge mclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    v = rd;
    r = rre;
    rr <= 1'b0;
    @(posedge mclk);
  endtask
  function automatic logic [31:0] shots_exp(input logic [3:0] a, input logic [3:0] b);
    return {24'h0, (b >= 4'h1 && b <= 4'h4) ? b : 4'h1, (a >= 4'h1 && a <= 4'h4) ? a : 4'h1};
  endfunction
  function automatic logic flag(input int k);
    case (k)
      0: return st.reclose_in_progress;
      1: return st.three_phase_close;
      2: return st.lockout;
      3: return st.trip_test_out;
      default: return st.in_service;
    endcase
  endfunction
  // Waits a bounded time for a status flag to reach the wanted level
  task automatic wait_flag(input string nm, input int k, input logic want, input int lim);
    for (int i = 0; i < lim && flag(k) !== want; i++) @(posedge mclk);
    chk(nm, {31'h0, flag(k)}, {31'h0, want});
  endtask
  task automatic fault();
    prot.main_start <= 1'b1;
    prot.main_trip <= 1'b1;
    repeat (8) @(posedge mclk);
    prot <= '0;
    @(posedge mclk);
  endtask
  task automatic clear_lockout();
    md.lockout_reset <= 1'b1;
    repeat (8) @(posedge mclk);
    md.lockout_reset <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {rst_n, mc, awv, wv, br, arv, rr, aw, ar, wd} = '0;
    ws = 4'hf;
    prot = '0;
    md = '0;
    cb = 7'h3b;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    rdr(reclose_pkg::ADDR_SHOTS);
    chk("shots rst", v, 32'h11);
    rdr(reclose_pkg::ADDR_DEAD1);
    chk("dead rst", v, {8'h0, reclose_pkg::DEAD_RST});
    rdr(8'h24);
    chk("unmapped rd", {30'h0, r}, {30'h0, reclose_pkg::RESP_SLVERR});
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 4'h5 : 4'($random(seed));
      s = 4'($random(seed));
      d = {8'h0, 24'($random(seed))};
      wr(reclose_pkg::ADDR_SHOTS, {24'h0, s, m});
      rdr(reclose_pkg::ADDR_SHOTS);
      chk("shots", v, shots_exp(m, s));
      wr(reclose_pkg::ADDR_DEAD1 + 8'(4 * (i % 4)), d);
      rdr(reclose_pkg::ADDR_DEAD1 + 8'(4 * (i % 4)));
      chk("dead", v, d);
    end
    for (int i = 0; i < 6; i++) wr(reclose_pkg::ADDR_DEAD1 + 8'(4 * i), (i == 4) ? 2 : 1);
    wr(reclose_pkg::ADDR_SHOTS, 32'h11);
    $display("registers done");
    md.auto_mode_select_b <= 1'b1;
    wait_flag("auto b", 4, 1'b1, 20);
    md.live_work_mode <= 1'b1;
    wait_flag("live work", 4, 1'b0, 20);
    chk("inst block", {31'h0, st.block_inst_prot}, 32'h0);
    // Remote control mode only
    md <= 11'h080;
    wr(reclose_pkg::ADDR_CTRL, 32'h2);
    wait_flag("remote on", 4, 1'b1, 20);
    wr(reclose_pkg::ADDR_CTRL, 32'h0);
    wait_flag("remote off", 4, 1'b0, 20);
    // First auto select only
    md <= 11'h400;
    wait_flag("auto a", 4, 1'b1, 20);
    $display("modes done");
    fault();
    wait_flag("in progress", 0, 1'b1, 20);
    chk("count 1", {29'h0, st.seq_count}, 32'h1);
    chk("inst block on", {31'h0, st.block_inst_prot}, 32'h1);
    wait_flag("close", 1, 1'b1, 9000);
    wait_flag("closed", 1, 1'b0, 100);
    repeat (100) @(posedge mclk);
    fault();
    wait_flag("shots used", 2, 1'b1, 50);
    wait_flag("ends at lockout", 0, 1'b0, 20);
    clear_lockout();
    wait_flag("lockout reset", 2, 1'b0, 50);
    $display("lockout cycle done");
    mc <= 1'b1;
    repeat (40) @(posedge mclk);
    mc <= 1'b0;
    cb.one_side_live <= 1'b0;
    repeat (20) @(posedge mclk);
    fault();
    repeat (9000) @(posedge mclk);
    chk("no sys check", {31'h0, st.three_phase_close}, 32'h0);
    cb.both_live_sync <= 1'b1;
    wait_flag("synced close", 1, 1'b1, 100);
    chk("dar tracks", {31'h0, st.delayed_reclose_in_progress}, 32'h1);
    md.delayed_reclose_complete <= 1'b1;
    repeat (8) @(posedge mclk);
    md.delayed_reclose_complete <= 1'b0;
    chk("dar done", {31'h0, st.delayed_reclose_in_progress}, 32'h0);
    chk("ar stays", {31'h0, st.reclose_in_progress}, 32'h1);
    wait_flag("reclaim end", 0, 1'b0, 15000);
    chk("count 0", {29'h0, st.seq_count}, 32'h0);
    $display("reclose cycle done");
    md.reclose_block <= 1'b1;
    wait_flag("block", 2, 1'b1, 20);
    clear_lockout();
    repeat (10) @(posedge mclk);
    chk("held by block", {31'h0, st.lockout}, 32'h1);
    md.reclose_block <= 1'b0;
    repeat (10) @(posedge mclk);
    clear_lockout();
    wait_flag("unblock", 2, 1'b0, 50);
    cb.breaker_energy_ok <= 1'b0;
    fault();
    wait_flag("energy lock", 2, 1'b1, 9000);
    chk("energy alarm", {31'h0, st.energy_alarm}, 32'h1);
    cb.breaker_energy_ok <= 1'b1;
    clear_lockout();
    wait_flag("energy reset", 2, 1'b0, 50);
    chk("alarm cleared", {31'h0, st.energy_alarm}, 32'h0);
    md.skip_first_shot <= 1'b1;
    repeat (8) @(posedge mclk);
    md.skip_first_shot <= 1'b0;
    chk("skip shot", {29'h0, st.seq_count}, 32'h1);
    md.trip_test_request <= 1'b1;
    wait_flag("trip test", 3, 1'b1, 20);
    md.trip_test_request <= 1'b0;
    $display("block and trip test done");
    wrap_up();
  end
endmodule
`default_nettype wire
